// File: design/sgc_regs.sv
// Global control, reserved byte and scratch register slice of the switch
//
// Contract
// - Global control bit 6 set puts the PHYs into power save; resets 0.
// - Bit 1 drives only low indicator scheme select; reset value from strap pin.
// - High scheme select comes only from its strap; both pick the indicator map.
// - Bit 0 enables special tag handling for port 3 direct forwarding; resets 0.
// - Three 8-bit scratch bytes at 0x0D-0x0F, read/write, reset 0x00, no effect.
// - Byte 0x0C is reserved and reads zero.
// - Per-port registers share one layout, each port at its own address.
`timescale 1ns/1ns
module sgc_regs
   import sgc_pkg::*;
(
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic [ADDR_W-1:0]     reg_addr,
   input  wire logic [DATA_W-1:0]     reg_wdata,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   output logic      [DATA_W-1:0]     reg_rdata,
   input  wire logic                  strap_scheme_low,
   input  wire logic                  strap_scheme_high,
   input  wire logic [NUM_PORTS-1:0]  port_link,
   input  wire logic [NUM_PORTS-1:0]  port_activity,
   input  wire logic [NUM_PORTS-1:0]  port_full_duplex,
   input  wire logic [NUM_PORTS-1:0]  port_collision,
   input  wire logic [NUM_PORTS-1:0]  port_speed_100,
   output logic                       phy_power_save,
   output logic                       tag_special_en,
   output logic                       test_mode,
   output logic      [NUM_PORTS-1:0]  port_indicator_zero,
   output logic      [NUM_PORTS-1:0]  port_indicator_one,
   output logic      [NUM_PORTS-1:0]  port_indicator_two,
   output logic      [NUM_PORTS-1:0]  port_indicator_three
);
   // ************************************************************
   // Strap synchronisers
   // ************************************************************
   logic [1:0]        strap_low_sync_reg;
   logic [1:0]        strap_high_sync_reg;
   logic [1:0]        settle_cnt_reg;
   logic              strap_window;
   logic [DATA_W-1:0] gctrl_reg;
   logic [DATA_W-1:0] ctl_rdata_reg;
   sgc_scheme_t       scheme;
   sgc_scratch_if     scr_bus ();

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         strap_low_sync_reg  <= 2'h0;
         strap_high_sync_reg <= 2'h0;
      end else begin
         strap_low_sync_reg  <= {strap_low_sync_reg[0], strap_scheme_low};
         strap_high_sync_reg <= {strap_high_sync_reg[0], strap_scheme_high};
      end
   end

   // Strap pins are sampled after release; async reset may only load constants
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         settle_cnt_reg <= 2'h0;
      end else if (settle_cnt_reg != STRAP_SETTLE) begin
         settle_cnt_reg <= settle_cnt_reg + 2'h1;
      end
   end
   assign strap_window = (settle_cnt_reg != STRAP_SETTLE);

   // ************************************************************
   // Global control register
   // ************************************************************
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         gctrl_reg <= GCTRL_RESET;
      end else begin
         if (reg_wr && reg_addr == OFF_GLOBAL_CTRL) begin
            gctrl_reg <= reg_wdata & GCTRL_WR_MASK;
         end
         // Strap copy stays live until the synchroniser has settled
         if (strap_window) begin
            gctrl_reg[BIT_SCHEME_LOW] <= strap_low_sync_reg[1];
         end
      end
   end

   assign phy_power_save = gctrl_reg[BIT_PWR_SAVE];
   assign tag_special_en = gctrl_reg[BIT_TAG_SPECIAL];
   // Exposed so a stray one from software is visible; no logic here acts on it
   assign test_mode      = gctrl_reg[BIT_TEST_MODE];

   // ************************************************************
   // Indicator scheme
   // ************************************************************
   assign scheme = sgc_scheme_t'({strap_high_sync_reg[1], gctrl_reg[BIT_SCHEME_LOW]});

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         port_indicator_zero  <= '0;
         port_indicator_one   <= '0;
         port_indicator_two   <= '0;
         port_indicator_three <= '0;
      end else begin
         case (scheme)
            SGC_SCHEME_A: begin
               port_indicator_three <= '0;
               port_indicator_two   <= port_link & ~port_activity;
               port_indicator_one   <= port_full_duplex | port_collision;
               port_indicator_zero  <= port_speed_100;
            end
            SGC_SCHEME_B: begin
               port_indicator_three <= '0;
               port_indicator_two   <= port_link & port_speed_100 & ~port_activity;
               port_indicator_one   <= port_link & ~port_speed_100 & ~port_activity;
               port_indicator_zero  <= port_full_duplex;
            end
            SGC_SCHEME_C: begin
               port_indicator_three <= port_activity;
               port_indicator_two   <= port_link;
               port_indicator_one   <= port_full_duplex | port_collision;
               port_indicator_zero  <= port_speed_100;
            end
            default: begin
               // Scheme 11 has no defined mapping, indicators stay dark
               port_indicator_three <= '0;
               port_indicator_two   <= '0;
               port_indicator_one   <= '0;
               port_indicator_zero  <= '0;
            end
         endcase
      end
   end

   // ************************************************************
   // Register read path
   // ************************************************************
   assign scr_bus.wr    = reg_wr && sgc_is_scratch(reg_addr);
   assign scr_bus.rd    = reg_rd && sgc_is_scratch(reg_addr);
   assign scr_bus.idx   = 2'(reg_addr - OFF_SCRATCH_ONE);
   assign scr_bus.wdata = reg_wdata;

   sgc_scratch_mem u_scratch (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .bus     (scr_bus.store)
   );

   // Reserved byte, per-port range and unmapped offsets read zero here
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctl_rdata_reg <= '0;
      end else if (reg_rd && reg_addr == OFF_GLOBAL_CTRL) begin
         ctl_rdata_reg <= gctrl_reg;
      end else if (reg_rd && reg_addr == OFF_RESERVED) begin
         ctl_rdata_reg <= RESERVED_VALUE;
      end else begin
         ctl_rdata_reg <= '0;
      end
   end

   // Both sources are zero unless they answered, so no select flop is needed
   assign reg_rdata = ctl_rdata_reg | scr_bus.rdata;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_power_save_follow : assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_wr && reg_addr == OFF_GLOBAL_CTRL |=> phy_power_save == $past(reg_wdata[6]))
      else $error("power save does not follow control bit 6");

   a_tag_special_follow : assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_wr && reg_addr == OFF_GLOBAL_CTRL |=> tag_special_en == $past(reg_wdata[0]))
      else $error("special tag enable does not follow control bit 0");

   a_strap_low_load : assert property (@(posedge clk_sys) disable iff (!rst_n)
      strap_window && !(reg_wr && reg_addr == OFF_GLOBAL_CTRL)
      |=> gctrl_reg[1] == $past(strap_low_sync_reg[1]))
      else $error("low scheme select not loaded from strap");

   a_scheme_high_strap : assert property (@(posedge clk_sys) disable iff (!rst_n)
      !strap_window |-> scheme[1] == $past(strap_scheme_high, 2))
      else $error("high scheme select not taken from its strap pin");

   a_scheme_c_activity : assert property (@(posedge clk_sys) disable iff (!rst_n)
      scheme == SGC_SCHEME_C ##1 scheme == SGC_SCHEME_C
      |-> port_indicator_three == $past(port_activity))
      else $error("scheme 10 activity indicator wrong");

   a_test_bit_reset : assert property (@(posedge clk_sys)
      $rose(rst_n) |-> !test_mode && gctrl_reg[3])
      else $error("test bit or bit 3 reset value wrong");

   a_reserved_reads_zero : assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr == OFF_RESERVED |=> reg_rdata == 8'h00)
      else $error("reserved byte read nonzero");

   a_port_range_zero : assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr >= sgc_port_addr(2'h0, 4'h0) |=> reg_rdata == 8'h00)
      else $error("port range read nonzero in this slice");

   a_gctrl_readback : assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_rd && reg_addr == OFF_GLOBAL_CTRL |=> reg_rdata == $past(gctrl_reg) && !reg_rdata[7])
      else $error("global control readback wrong");

   c_power_save_on  : cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(phy_power_save));
   c_scratch_read   : cover property (@(posedge clk_sys) disable iff (!rst_n) scr_bus.rd ##1 reg_rdata != 8'h00);
   c_scheme_c_used  : cover property (@(posedge clk_sys) disable iff (!rst_n) scheme == SGC_SCHEME_C);
endmodule

// File: shared/sgc_pkg.sv
// Constants for the global control and scratch register slice
package sgc_pkg;
   localparam int       ADDR_W          = 8;
   localparam int       DATA_W          = 8;
   localparam int       NUM_SCRATCH     = 3;
   localparam int       NUM_PORTS       = 3;
   localparam int       IND_W           = 4;
   // Register offsets
   localparam logic [7:0] OFF_GLOBAL_CTRL = 8'h0B;
   localparam logic [7:0] OFF_RESERVED    = 8'h0C;
   localparam logic [7:0] OFF_SCRATCH_ONE = 8'h0D;
   localparam logic [7:0] OFF_SCRATCH_TWO = 8'h0E;
   localparam logic [7:0] OFF_SCRATCH_THR = 8'h0F;
   localparam logic [7:0] OFF_PORT_BASE   = 8'h10;
   localparam logic [7:0] OFF_PORT_STRIDE = 8'h10;
   // Global control field positions
   localparam int       BIT_PWR_SAVE    = 6;
   localparam int       BIT_RSVD5       = 5;
   localparam int       BIT_TEST_MODE   = 4;
   localparam int       BIT_RSVD3       = 3;
   localparam int       BIT_RSVD2       = 2;
   localparam int       BIT_SCHEME_LOW  = 1;
   localparam int       BIT_TAG_SPECIAL = 0;
   // Bits software may change; bit 7 reads zero, bit 1 is loaded from the strap
   localparam logic [7:0] GCTRL_WR_MASK   = 8'h7F;
   localparam logic [7:0] GCTRL_RESET     = 8'h08;
   localparam logic [7:0] SCRATCH_RESET   = 8'h00;
   localparam logic [7:0] RESERVED_VALUE  = 8'h00;
   // Cycles after reset release until the synchronised strap is valid
   localparam logic [1:0] STRAP_SETTLE    = 2'h3;

   typedef enum logic [1:0] {
      SGC_SCHEME_A = 2'b00,
      SGC_SCHEME_B = 2'b01,
      SGC_SCHEME_C = 2'b10,
      SGC_SCHEME_D = 2'b11
   } sgc_scheme_t;

   // Offset of register idx of a given port (identical layout per port)
   function automatic logic [7:0] sgc_port_addr(input logic [1:0] port,
                                                input logic [3:0] idx);
      sgc_port_addr = OFF_PORT_BASE + ({6'h00, port} * OFF_PORT_STRIDE) + {4'h0, idx};
   endfunction

   function automatic logic sgc_is_scratch(input logic [7:0] addr);
      sgc_is_scratch = (addr == OFF_SCRATCH_ONE) || (addr == OFF_SCRATCH_TWO)
                       || (addr == OFF_SCRATCH_THR);
   endfunction
endpackage

// File: shared/sgc_scratch_if.sv
// Carrier between the register top and the scratch store
`timescale 1ns/1ns
interface sgc_scratch_if;
   import sgc_pkg::*;
   logic              wr;
   logic              rd;
   logic [1:0]        idx;
   logic [DATA_W-1:0] wdata;
   logic [DATA_W-1:0] rdata;
   modport ctrl  (output wr, output rd, output idx, output wdata, input rdata);
   modport store (input wr, input rd, input idx, input wdata, output rdata);
endinterface

// File: design/sgc_scratch_mem.sv
// Three user scratch bytes with registered read data
`timescale 1ns/1ns
module sgc_scratch_mem
   import sgc_pkg::*;
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   sgc_scratch_if.store    bus
);
   logic [DATA_W-1:0] mem_reg [NUM_SCRATCH];

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_SCRATCH; i++) begin
            mem_reg[i] <= SCRATCH_RESET;
         end
      end else if (bus.wr && (bus.idx < 2'(NUM_SCRATCH))) begin
         mem_reg[bus.idx] <= bus.wdata;
      end
   end

   // Zero when no read, so the top can merge sources with an OR
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         bus.rdata <= '0;
      end else if (bus.rd && (bus.idx < 2'(NUM_SCRATCH))) begin
         bus.rdata <= mem_reg[bus.idx];
      end else begin
         bus.rdata <= '0;
      end
   end

   a_scratch_readback : assert property (@(posedge clk_sys) disable iff (!rst_n)
      bus.wr && bus.idx == 2'h0 ##1 !bus.wr ##0 bus.rd && bus.idx == 2'h0
      |=> bus.rdata == $past(bus.wdata, 2))
      else $error("scratch byte did not read back written value");
endmodule

// File: tb/tb_top.sv
// Self-checking testbench for the global control and scratch register slice
`timescale 1ns/1ns
module tb_top
   import sgc_pkg::*;
;
   // ************************************************************
   // Signals
   // ************************************************************
   logic                 clk_sys;
   logic                 rst_n;
   logic [ADDR_W-1:0]    reg_addr;
   logic [DATA_W-1:0]    reg_wdata;
   logic                 reg_wr;
   logic                 reg_rd;
   logic [DATA_W-1:0]    reg_rdata;
   logic                 strap_scheme_low;
   logic                 strap_scheme_high;
   logic [NUM_PORTS-1:0] lnk, act, dpx, col, spd;
   logic                 phy_power_save;
   logic                 tag_special_en;
   logic                 test_mode;
   logic [NUM_PORTS-1:0] ind0, ind1, ind2, ind3;
   int                   err_count;
   int                   checks_done;

   sgc_regs u_dut (
      .clk_sys              (clk_sys),
      .rst_n                (rst_n),
      .reg_addr             (reg_addr),
      .reg_wdata            (reg_wdata),
      .reg_wr               (reg_wr),
      .reg_rd               (reg_rd),
      .reg_rdata            (reg_rdata),
      .strap_scheme_low     (strap_scheme_low),
      .strap_scheme_high    (strap_scheme_high),
      .port_link            (lnk),
      .port_activity        (act),
      .port_full_duplex     (dpx),
      .port_collision       (col),
      .port_speed_100       (spd),
      .phy_power_save       (phy_power_save),
      .tag_special_en       (tag_special_en),
      .test_mode            (test_mode),
      .port_indicator_zero  (ind0),
      .port_indicator_one   (ind1),
      .port_indicator_two   (ind2),
      .port_indicator_three (ind3)
   );

   always #4 clk_sys = ~clk_sys;

   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic summarize();
      if (err_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
      #1;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1 chk({4'h0, reg_rdata}, {4'h0, e});
   endtask

   // Strap window needs 3 edges after release before software may write
   task automatic do_reset(input logic s);
      rst_n            <= 1'b0;
      strap_scheme_low <= s;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
   endtask

   function automatic logic [11:0] exp_ind(input logic [1:0] s, input logic [2:0] l, a, d, c, p);
      case (s)
         2'b00:   exp_ind = {3'h0, l & ~a, d | c, p};
         2'b01:   exp_ind = {3'h0, l & p & ~a, l & ~p & ~a, d};
         2'b10:   exp_ind = {a, l, d | c, p};
         default: exp_ind = 12'h000;
      endcase
   endfunction

   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      clk_sys = 1'b0; rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
      reg_wr = 1'b0; reg_rd = 1'b0; strap_scheme_low = 1'b1; strap_scheme_high = 1'b0;
      lnk = 3'h0; act = 3'h0; dpx = 3'h0; col = 3'h0; spd = 3'h0;
      err_count = 0; checks_done = 0;
      do_reset(1'b1);
      rd(OFF_GLOBAL_CTRL, 8'h0A);
      chk({9'h000, phy_power_save, tag_special_en, test_mode}, 12'h000);
      rd(OFF_RESERVED, 8'h00);
      rd(OFF_SCRATCH_ONE, 8'h00);
      rd(OFF_SCRATCH_THR, 8'h00);
      // Strap is only captured around reset
      strap_scheme_low <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rd(OFF_GLOBAL_CTRL, 8'h0A);
      wr(OFF_GLOBAL_CTRL, 8'h49);
      chk({9'h000, phy_power_save, tag_special_en, test_mode}, 12'h006);
      rd(OFF_GLOBAL_CTRL, 8'h49);
      wr(OFF_GLOBAL_CTRL, 8'hEF);
      rd(OFF_GLOBAL_CTRL, 8'h6F);
      wr(OFF_GLOBAL_CTRL, 8'h08);
      chk({9'h000, phy_power_save, tag_special_en, test_mode}, 12'h000);
      wr(OFF_SCRATCH_ONE, 8'hA5);
      wr(OFF_SCRATCH_TWO, 8'h5A);
      wr(OFF_SCRATCH_THR, 8'hFF);
      wr(OFF_RESERVED, 8'hFF);
      rd(OFF_SCRATCH_ONE, 8'hA5);
      rd(OFF_SCRATCH_TWO, 8'h5A);
      rd(OFF_SCRATCH_THR, 8'hFF);
      rd(OFF_RESERVED, 8'h00);
      rd(OFF_GLOBAL_CTRL, 8'h08);
      chk({9'h000, phy_power_save, tag_special_en, test_mode}, 12'h000);
      rd(OFF_PORT_BASE, 8'h00);
      // Write then read back with no idle cycle between the strobes
      @(posedge clk_sys);
      reg_wr    <= 1'b1;
      reg_addr  <= OFF_SCRATCH_ONE;
      reg_wdata <= 8'h3C;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk({4'h0, reg_rdata}, 12'h03C);
      // Every scheme, one status pattern and its inverse
      for (int s = 0; s < 4; s++) begin
         for (int k = 0; k < 2; k++) begin
            strap_scheme_high <= s[1];
            wr(OFF_GLOBAL_CTRL, {6'h02, s[0], 1'b0});
            lnk <= 3'b011 ^ {3{k[0]}};
            act <= 3'b001 ^ {3{k[0]}};
            dpx <= 3'b100 ^ {3{k[0]}};
            col <= 3'b010 ^ {3{k[0]}};
            spd <= 3'b101 ^ {3{k[0]}};
            repeat (6) @(posedge clk_sys);
            #1 chk({ind3, ind2, ind1, ind0},
                   exp_ind(s[1:0], lnk, act, dpx, col, spd));
            rd(OFF_GLOBAL_CTRL, {6'h02, s[0], 1'b0});
         end
      end
      // Second reset in mid-run with the other strap level
      wr(OFF_GLOBAL_CTRL, 8'h4B);
      do_reset(1'b0);
      rd(OFF_GLOBAL_CTRL, 8'h08);
      chk({9'h000, phy_power_save, tag_special_en, test_mode}, 12'h000);
      rd(OFF_SCRATCH_ONE, 8'h00);
      rd(OFF_SCRATCH_THR, 8'h00);
      summarize();
   end

   // Hang guard, far beyond the sequence length
   initial begin
      #100000;
      err_count++;
      summarize();
   end
endmodule
